// *** testbench/gpio_port_sva.sv ***
/*
 * Checker for the eight-pin port.
 * Assumes it is bound to gpio_port and sees only its ports.
 */
`timescale 1ns/1ps
`include "gpio_port_regs.vh"
module gpio_port_sva #(
    parameter PIN_COUNT = 8
) (
    // Clock and reset.
    input wire core_clk_i,
    input wire nrst_i,
    // Register port.
    input wire [15:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_word_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [15:0] reg_rdata_o,
    // Pins and forwarded levels.
    input wire [PIN_COUNT-1:0] port_pin_in_i,
    input wire [PIN_COUNT-1:0] port_pin_oe_o,
    input wire [PIN_COUNT-1:0] pull_up_en_o,
    input wire [PIN_COUNT-1:0] pull_down_en_o,
    input wire uart_receive_o,
    input wire timer_even_ext_clock_o,
    input wire timer_odd_ext_clock_o
);
    reg [2:0] alive;
    wire mapped;
    wire drv_wr;
    wire fun_wr;

    // Forwarding checks wait until the synchroniser has refilled.
    always @(posedge core_clk_i)
    begin
        if (!nrst_i)
            alive <= 3'h0;
        else if (alive != 3'h7)
            alive <= alive + 3'h1;
    end
    assign mapped = reg_addr_i >= `ADDR_PORT_DATA &&
                    reg_addr_i <= `ADDR_FUNCTION_SELECT_HIGH;
    assign drv_wr = reg_word_i && reg_addr_i == `ADDR_DRIVE_CONFIG_LOW;
    assign fun_wr = reg_word_i && reg_addr_i == `ADDR_FUNCTION_SELECT_LOW;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    AST_RD_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("read data not zero outside a read");
    AST_RD_UNMAP: assert property (reg_rd_i && !mapped |=>
        reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
    AST_RD_BYTE: assert property (reg_rd_i && !drv_wr && !fun_wr |=>
        reg_rdata_o[15:8] == 8'h00) else $error("byte read upper not zero");
    AST_DIR_RB: assert property (reg_wr_i &&
        reg_addr_i == `ADDR_PORT_DIRECTION ##1 reg_rd_i &&
        reg_addr_i == `ADDR_PORT_DIRECTION |=>
        reg_rdata_o[7:0] == $past(reg_wdata_i[7:0], 2))
        else $error("direction readback wrong");
    AST_DRV_RB: assert property (reg_wr_i && drv_wr ##1
        reg_rd_i && drv_wr |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("drive word readback wrong");
    AST_FUN_RB: assert property (reg_wr_i && fun_wr ##1
        reg_rd_i && fun_wr |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("function word readback wrong");
    AST_PULL_EXCL: assert property ((pull_up_en_o & pull_down_en_o) == '0)
        else $error("pull-up and pull-down both on");
    AST_RST_OUT: assert property ($rose(nrst_i) |-> port_pin_oe_o == '0 &&
        pull_up_en_o == '0 && pull_down_en_o == '0 &&
        reg_rdata_o == 16'h0000) else $error("outputs not idle after reset");
    AST_TMR_EVEN: assert property ((alive == 3'h7 &&
        $stable(port_pin_in_i[4])) [*4] |->
        timer_even_ext_clock_o == port_pin_in_i[4])
        else $error("even timer clock does not follow pin 4");
    AST_TMR_ODD: assert property ((alive == 3'h7 &&
        $stable(port_pin_in_i[5])) [*4] |->
        timer_odd_ext_clock_o == port_pin_in_i[5])
        else $error("odd timer clock does not follow pin 5");
    AST_UART_RX: assert property ((alive == 3'h7 &&
        $stable(port_pin_in_i[2])) [*4] |->
        uart_receive_o == port_pin_in_i[2])
        else $error("uart receive does not follow pin 2");
endmodule

bind gpio_port gpio_port_sva #(.PIN_COUNT(PIN_COUNT)) sva_inst (.*);

// *** testbench/pin_world.sv ***
/*
 * Board model resolving each pin level.
 * Assumes the bench never drives a pin that the port drives.
 */
`timescale 1ns/1ps
module pin_world (
    // Clock for the floating-pin pattern.
    input wire core_clk_i,
    // Port drive.
    input wire [7:0] pin_out_i,
    input wire [7:0] pin_oe_i,
    input wire [7:0] pull_up_i,
    input wire [7:0] pull_down_i,
    // External driver.
    input wire [7:0] ext_val_i,
    input wire [7:0] ext_en_i,
    // Resolved levels.
    output reg [7:0] level_o
);
    reg [7:0] noise = 8'h55;
    integer i;

    // A floating pin toggles so nothing can lean on a stale level.
    always @(posedge core_clk_i)
    begin
        noise <= ~noise;
    end
    always @*
    begin
        for (i = 0; i < 8; i = i + 1)
        begin
            if (pin_oe_i[i])
                level_o[i] = pin_out_i[i];
            else if (ext_en_i[i])
                level_o[i] = ext_val_i[i];
            else if (pull_up_i[i] | pull_down_i[i])
                level_o[i] = pull_up_i[i];
            else
                level_o[i] = noise[i];
        end
    end
endmodule

// *** testbench/tb.sv ***
/*
 * Bench for the eight-pin port: registers, drives, functions, inputs.
 * Assumes pin_world models the board.
 */
`timescale 1ns/1ps
module tb;
    logic core_clk_i;
    logic nrst_i;
    logic [15:0] reg_addr_i;
    logic [15:0] reg_wdata_i;
    logic reg_word_i;
    logic reg_wr_i;
    logic reg_rd_i;
    logic [14:0] pv;
    logic [7:0] msk;
    logic [7:0] ext_val;
    logic [7:0] ext_en;
    logic [15:0] a;
    logic [15:0] d;
    integer errors;
    integer checked;
    integer i;
    wire [15:0] reg_rdata_o;
    wire [7:0] port_pin_in_i;
    wire [7:0] port_pin_out_o;
    wire [7:0] port_pin_oe_o;
    wire [7:0] pull_up_en_o;
    wire [7:0] pull_down_en_o;
    wire i2c_data_out_i, i2c_data_oe_i, i2c_clock_out_i, i2c_clock_oe_i;
    wire uart_transmit_i, serial_port_data_out_i, serial_port_clock_out_i;
    wire serial_port_clock_oe_i, pwm_output_i, adc_ref_capacitor_out_i;
    wire adc_ref_capacitor_oe_i, adc_ref_resistor_out_i;
    wire adc_ref_resistor_oe_i, adc_sensor_resistor_out_i;
    wire adc_sensor_resistor_oe_i, i2c_data_in_o, i2c_clock_in_o;
    wire uart_receive_o, serial_port_data_in_o, serial_port_clock_in_o;
    wire adc_osc_waveform_in_o, timer_even_ext_clock_o;
    wire timer_odd_ext_clock_o;
    wire [4:0] sense;

    assign {i2c_data_out_i, i2c_data_oe_i, i2c_clock_out_i, i2c_clock_oe_i,
        uart_transmit_i, serial_port_data_out_i, serial_port_clock_out_i,
        serial_port_clock_oe_i, pwm_output_i, adc_ref_capacitor_out_i,
        adc_ref_capacitor_oe_i, adc_ref_resistor_out_i,
        adc_ref_resistor_oe_i, adc_sensor_resistor_out_i,
        adc_sensor_resistor_oe_i} = pv;
    assign sense = {timer_even_ext_clock_o, timer_odd_ext_clock_o,
        uart_receive_o, i2c_data_in_o, adc_osc_waveform_in_o};

    gpio_port #(.PIN_COUNT(8)) uut (.*);

    pin_world board (
        .core_clk_i, .pin_out_i(port_pin_out_o), .pin_oe_i(port_pin_oe_o),
        .pull_up_i(pull_up_en_o), .pull_down_i(pull_down_en_o),
        .ext_val_i(ext_val), .ext_en_i(ext_en), .level_o(port_pin_in_i)
    );

    always #20 core_clk_i = ~core_clk_i;

    task chk(input [15:0] got, input [15:0] exp);
    begin
        checked = checked + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask

    task wr(input [15:0] ad, input [15:0] dt, input w);
    begin
        if (reg_wr_i)
            @(posedge core_clk_i);
        reg_addr_i <= ad;
        reg_wdata_i <= dt;
        reg_word_i <= w;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    end
    endtask

    // Read data stand only in the cycle after the strobe.
    task rd(input [15:0] ad, input w, input [15:0] m, input [15:0] e);
    begin
        if (reg_rd_i)
            @(posedge core_clk_i);
        reg_addr_i <= ad;
        reg_word_i <= w;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        @(posedge core_clk_i);
        chk(reg_rdata_o & m, e);
    end
    endtask

    task row(input [7:0] dr, input [15:0] dc, input [15:0] fs,
             input [7:0] dt, input [7:0] eo, input [7:0] ev);
    begin
        wr(16'hf221, {8'h00, dr}, 1'b0);
        wr(16'hf222, dc, 1'b1);
        wr(16'hf224, fs, 1'b1);
        wr(16'hf220, {8'h00, dt}, 1'b0);
        repeat (2) @(posedge core_clk_i);
        chk({port_pin_oe_o & msk, port_pin_out_o & port_pin_oe_o & msk},
            {eo, ev});
    end
    endtask

    task close_out;
    begin
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask

    initial
    begin
        core_clk_i = 1'b0;
        nrst_i = 1'b0;
        reg_addr_i = 16'h0000;
        reg_wdata_i = 16'h0000;
        reg_word_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        pv = 15'h0000;
        msk = 8'hff;
        ext_val = 8'h00;
        ext_en = 8'h00;
        errors = 0;
        checked = 0;
        repeat (16) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        chk({port_pin_oe_o, pull_up_en_o | pull_down_en_o}, 16'h0000);
        for (i = 0; i < 6; i = i + 1)
            rd(16'hf220 + i[15:0], 1'b0, 16'hffff, 16'h0000);
        $display("reset test done");
        for (i = 0; i < 6; i = i + 1)
        begin
            a = 16'hf220 + i[15:0];
            d = {8'h00, 8'h5a ^ i[7:0]};
            wr(a, d, 1'b0);
            rd(a, 1'b1, 16'hffff, d);
        end
        wr(16'hf222, 16'h3cc3, 1'b1);
        rd(16'hf222, 1'b1, 16'hffff, 16'h3cc3);
        rd(16'hf223, 1'b0, 16'hffff, 16'h003c);
        wr(16'hf224, 16'h6996, 1'b1);
        rd(16'hf224, 1'b1, 16'hffff, 16'h6996);
        rd(16'hf225, 1'b0, 16'hffff, 16'h0069);
        wr(16'hf226, 16'hffff, 1'b0);
        rd(16'hf226, 1'b0, 16'hffff, 16'h0000);
        rd(16'hf21f, 1'b0, 16'hffff, 16'h0000);
        $display("register test done");
        row(8'h00, 16'hf0cc, 16'h0000, 8'haa, 8'hd8, 8'h88);
        row(8'h00, 16'hf0cc, 16'h0000, 8'h55, 8'he4, 8'h44);
        row(8'h00, 16'hf0cc, 16'hffff, 8'hff, 8'hf0, 8'h00);
        row(8'h00, 16'hf0cc, 16'h8000, 8'hff, 8'hcc, 8'h4c);
        pv <= 15'h6c36;
        msk <= 8'heb;
        row(8'h00, 16'hf0cc, 16'h00ff, 8'h00, 8'h6b, 8'h29);
        pv <= 15'h0380;
        msk <= 8'h6e;
        row(8'hff, 16'h0000, 16'h7f00, 8'h00, 8'h6e, 8'h66);
        repeat (4) @(posedge core_clk_i);
        chk({15'h0000, serial_port_clock_in_o}, 16'h0001);
        pv <= 15'h0000;
        msk <= 8'hff;
        $display("drive test done");
        row(8'hff, 16'hccaa, 16'h0000, 8'h00, 8'h00, 8'h00);
        chk({pull_up_en_o, pull_down_en_o}, 16'h4422);
        ext_en <= 8'hff;
        for (i = 0; i < 2; i = i + 1)
        begin
            ext_val <= i[0] ? 8'hc3 : 8'h3c;
            repeat (4) @(posedge core_clk_i);
            rd(16'hf220, 1'b0, 16'hffff, {8'h00, ext_val});
            chk({11'h000, sense}, i[0] ? 16'h0002 : 16'h001d);
        end
        ext_en <= 8'h00;
        repeat (4) @(posedge core_clk_i);
        rd(16'hf220, 1'b0, 16'h0066, 16'h0044);
        $display("input test done");
        close_out;
    end
endmodule

// *** verilog/gpio_pin_cell.v ***
/*
 * Drive decoder for one port pin: turns direction, drive field, function
 * field, data bit and peripheral drive into pin value, enable and pulls.
 * Assumes all inputs are on the system clock; the result is combinational
 * and is registered by the port module.
 */
`timescale 1ns/1ps
`include "gpio_port_regs.vh"

module gpio_pin_cell #(
    parameter HAS_TERTIARY = 1
) (
    // Configuration of this pin.
    input wire direction_i,
    input wire [1:0] drive_i,
    input wire [1:0] function_i,
    input wire data_i,
    // Peripheral drive for the secondary and tertiary functions.
    input wire alt2_out_i,
    input wire alt2_oe_i,
    input wire alt3_out_i,
    input wire alt3_oe_i,
    // Decoded pin controls.
    output reg next_out_o,
    output reg next_oe_o,
    output reg next_pull_up_o,
    output reg next_pull_down_o
);

    reg prohibited;

    always @*
    begin
        prohibited = (function_i == `FUNC_RESERVED) ||
            ((function_i == `FUNC_TERTIARY) && (HAS_TERTIARY == 0));
        next_out_o = 1'b0;
        next_oe_o = 1'b0;
        next_pull_up_o = 1'b0;
        next_pull_down_o = 1'b0;
        if (direction_i == `DIR_INPUT)
        begin
            // Pulls follow the drive field whatever function is selected.
            next_pull_down_o = (drive_i == `PULL_DOWN);
            next_pull_up_o = (drive_i == `PULL_UP);
        end
        if (prohibited)
        begin
            // Data bit ignored; the two strong-low codes pull the pin low.
            if (direction_i == `DIR_OUTPUT)
            begin
                next_oe_o = drive_i[1];
                next_out_o = 1'b0;
            end
        end
        else if (function_i == `FUNC_SECONDARY)
        begin
            next_out_o = alt2_out_i;
            next_oe_o = alt2_oe_i;
        end
        else if (function_i == `FUNC_TERTIARY)
        begin
            next_out_o = alt3_out_i;
            next_oe_o = alt3_oe_i;
        end
        else if (direction_i == `DIR_OUTPUT)
        begin
            case (drive_i)
                `DRIVE_P_OPEN:
                begin
                    next_out_o = 1'b1;
                    next_oe_o = data_i;
                end
                `DRIVE_N_OPEN:
                begin
                    next_out_o = 1'b0;
                    next_oe_o = ~data_i;
                end
                `DRIVE_CMOS:
                begin
                    next_out_o = data_i;
                    next_oe_o = 1'b1;
                end
                default:
                begin
                    next_out_o = 1'b0;
                    next_oe_o = 1'b0;
                end
            endcase
        end
    end

endmodule

// *** verilog/gpio_port.v ***
/*
 * Eight-pin general-purpose port with per-pin direction, drive mode,
 * pulls and secondary/tertiary function routing to on-chip peripherals.
 * Assumes a single-cycle register port on the system clock, external
 * resolution of each pin from value and enable, and peripherals on the
 * same clock.
 */
`timescale 1ns/1ps
`include "gpio_port_regs.vh"

// Notes on behaviour
// - Eight independent bidirectional pins, numbered 0-7.
// - Data register at 0xf220, reset zero.
// - Output pins driven from data register bits.
// - Output pins read back last written bit.
// - Input pins read back present pin level.
// - Zero means low, one means high.
// - Direction register 0xf221; zero output, one input.
// - Output drive: high-z, P-open, N-open, CMOS.
// - Input: high-z, pull-down or pull-up.
// - Drive config bytes 0xf222/3, word at 0xf222.
// - Function select bytes 0xf224/5, word at 0xf224.
// - Pins 4 and 5 feed timer clocks.
// - Alternate functions of pins 0 to 3.
// - Alternate functions of pins 4 to 7.
// - Drive field decode per direction.
// - Function codes; reserved and missing tertiary prohibited.
// - Prohibited output: float or hold low.
// - Reset: output, high-z, general purpose.
module gpio_port #(
    parameter PIN_COUNT = 8
) (
    // Clock and reset.
    input wire core_clk_i,
    input wire nrst_i,
    // Register port.
    input wire [15:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_word_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [15:0] reg_rdata_o,
    // Port pins.
    input wire [PIN_COUNT-1:0] port_pin_in_i,
    output reg [PIN_COUNT-1:0] port_pin_out_o,
    output reg [PIN_COUNT-1:0] port_pin_oe_o,
    output reg [PIN_COUNT-1:0] pull_up_en_o,
    output reg [PIN_COUNT-1:0] pull_down_en_o,
    // I2C drive and sampled levels.
    input wire i2c_data_out_i,
    input wire i2c_data_oe_i,
    input wire i2c_clock_out_i,
    input wire i2c_clock_oe_i,
    output reg i2c_data_in_o,
    output reg i2c_clock_in_o,
    // UART.
    input wire uart_transmit_i,
    output reg uart_receive_o,
    // Synchronous serial port.
    input wire serial_port_data_out_i,
    input wire serial_port_clock_out_i,
    input wire serial_port_clock_oe_i,
    output reg serial_port_data_in_o,
    output reg serial_port_clock_in_o,
    // PWM output.
    input wire pwm_output_i,
    // RC oscillation ADC.
    input wire adc_ref_capacitor_out_i,
    input wire adc_ref_capacitor_oe_i,
    input wire adc_ref_resistor_out_i,
    input wire adc_ref_resistor_oe_i,
    input wire adc_sensor_resistor_out_i,
    input wire adc_sensor_resistor_oe_i,
    output reg adc_osc_waveform_in_o,
    // Timer external clocks.
    output reg timer_even_ext_clock_o,
    output reg timer_odd_ext_clock_o
);

    // Configuration registers.
    reg [7:0] port_data;
    reg [7:0] port_direction;
    reg [7:0] drive_config_low;
    reg [7:0] drive_config_high;
    reg [7:0] function_select_low;
    reg [7:0] function_select_high;

    // Pin level synchroniser.
    reg [PIN_COUNT-1:0] pin_sync_meta;
    reg [PIN_COUNT-1:0] pin_level;

    // Peripheral drive per pin, gathered for the pin cells.
    wire [PIN_COUNT-1:0] alt2_out;
    wire [PIN_COUNT-1:0] alt2_oe;
    wire [PIN_COUNT-1:0] alt3_out;
    wire [PIN_COUNT-1:0] alt3_oe;

    // Decoded pin controls before the output flops.
    wire [PIN_COUNT-1:0] next_pin_out;
    wire [PIN_COUNT-1:0] next_pin_oe;
    wire [PIN_COUNT-1:0] next_pull_up;
    wire [PIN_COUNT-1:0] next_pull_down;

    reg [15:0] next_rdata;
    reg [7:0] data_readback;

    // A pin whose function field holds a given code.
    function func_is;
        input [7:0] low;
        input [7:0] high;
        input integer pin;
        input [1:0] code;
        begin
            func_is = ({high[pin], low[pin]} == code);
        end
    endfunction

    // Is a byte or word access aimed at the given register address.
    function hit;
        input [15:0] addr;
        input [15:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    // Each secondary function but two owns a drive; waveform input and UART
    // receive are input-only, so their enables stay low.
    assign alt2_out[0] = i2c_data_out_i;
    assign alt2_oe[0] = i2c_data_oe_i;
    assign alt2_out[1] = i2c_clock_out_i;
    assign alt2_oe[1] = i2c_clock_oe_i;
    assign alt2_out[2] = 1'b0;
    assign alt2_oe[2] = 1'b0;
    assign alt2_out[3] = uart_transmit_i;
    assign alt2_oe[3] = 1'b1;
    assign alt2_out[4] = 1'b0;
    assign alt2_oe[4] = 1'b0;
    assign alt2_out[5] = adc_ref_capacitor_out_i;
    assign alt2_oe[5] = adc_ref_capacitor_oe_i;
    assign alt2_out[6] = adc_ref_resistor_out_i;
    assign alt2_oe[6] = adc_ref_resistor_oe_i;
    assign alt2_out[7] = adc_sensor_resistor_out_i;
    assign alt2_oe[7] = adc_sensor_resistor_oe_i;

    assign alt3_out[0] = 1'b0;
    assign alt3_oe[0] = 1'b0;
    assign alt3_out[1] = serial_port_clock_out_i;
    assign alt3_oe[1] = serial_port_clock_oe_i;
    assign alt3_out[2] = serial_port_data_out_i;
    assign alt3_oe[2] = 1'b1;
    assign alt3_out[3] = pwm_output_i;
    assign alt3_oe[3] = 1'b1;
    assign alt3_out[4] = 1'b0;
    assign alt3_oe[4] = 1'b0;
    assign alt3_out[5] = serial_port_clock_out_i;
    assign alt3_oe[5] = serial_port_clock_oe_i;
    assign alt3_out[6] = serial_port_data_out_i;
    assign alt3_oe[6] = 1'b1;
    // Pin 7 has no tertiary function; its cell treats the code as
    // prohibited, so these values are never selected.
    assign alt3_out[7] = 1'b0;
    assign alt3_oe[7] = 1'b0;

    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi = gi + 1)
        begin : pin_cells
            gpio_pin_cell #(
                .HAS_TERTIARY((`TERTIARY_PINS >> gi) & 1)
            ) u_cell (
                .direction_i(port_direction[gi]),
                .drive_i({drive_config_high[gi], drive_config_low[gi]}),
                .function_i({function_select_high[gi],
                    function_select_low[gi]}),
                .data_i(port_data[gi]),
                .alt2_out_i(alt2_out[gi]),
                .alt2_oe_i(alt2_oe[gi]),
                .alt3_out_i(alt3_out[gi]),
                .alt3_oe_i(alt3_oe[gi]),
                .next_out_o(next_pin_out[gi]),
                .next_oe_o(next_pin_oe[gi]),
                .next_pull_up_o(next_pull_up[gi]),
                .next_pull_down_o(next_pull_down[gi])
            );
        end
    endgenerate

    // The first stage is read only by the second; everything else sees
    // pin_level, at the cost of two cycles of input latency.
    always @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            pin_sync_meta <= {PIN_COUNT{1'b0}};
            pin_level <= {PIN_COUNT{1'b0}};
        end
        else
        begin
            pin_sync_meta <= port_pin_in_i;
            pin_level <= pin_sync_meta;
        end
    end

    // Register writes. A word access only exists at the two paired
    // addresses; elsewhere the word flag is ignored and a byte is written.
    always @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            port_data <= `RST_PORT_DATA;
            port_direction <= `RST_PORT_DIRECTION;
            drive_config_low <= `RST_DRIVE_CONFIG_LOW;
            drive_config_high <= `RST_DRIVE_CONFIG_HIGH;
            function_select_low <= `RST_FUNCTION_SELECT_LOW;
            function_select_high <= `RST_FUNCTION_SELECT_HIGH;
        end
        else if (reg_wr_i)
        begin
            if (hit(reg_addr_i, `ADDR_PORT_DATA))
            begin
                port_data <= reg_wdata_i[7:0];
            end
            else if (hit(reg_addr_i, `ADDR_PORT_DIRECTION))
            begin
                port_direction <= reg_wdata_i[7:0];
            end
            else if (hit(reg_addr_i, `ADDR_DRIVE_CONFIG_LOW))
            begin
                drive_config_low <= reg_wdata_i[7:0];
                if (reg_word_i)
                begin
                    drive_config_high <= reg_wdata_i[15:8];
                end
            end
            else if (hit(reg_addr_i, `ADDR_DRIVE_CONFIG_HIGH))
            begin
                drive_config_high <= reg_wdata_i[7:0];
            end
            else if (hit(reg_addr_i, `ADDR_FUNCTION_SELECT_LOW))
            begin
                function_select_low <= reg_wdata_i[7:0];
                if (reg_word_i)
                begin
                    function_select_high <= reg_wdata_i[15:8];
                end
            end
            else if (hit(reg_addr_i, `ADDR_FUNCTION_SELECT_HIGH))
            begin
                function_select_high <= reg_wdata_i[7:0];
            end
        end
    end

    // Input pins return the synchronised level, output pins the latch.
    always @*
    begin
        data_readback = (port_direction & pin_level) |
            (~port_direction & port_data);
    end

    always @*
    begin
        next_rdata = 16'h0000;
        if (hit(reg_addr_i, `ADDR_PORT_DATA))
        begin
            next_rdata = {8'h00, data_readback};
        end
        else if (hit(reg_addr_i, `ADDR_PORT_DIRECTION))
        begin
            next_rdata = {8'h00, port_direction};
        end
        else if (hit(reg_addr_i, `ADDR_DRIVE_CONFIG_LOW))
        begin
            if (reg_word_i)
            begin
                next_rdata = {drive_config_high, drive_config_low};
            end
            else
            begin
                next_rdata = {8'h00, drive_config_low};
            end
        end
        else if (hit(reg_addr_i, `ADDR_DRIVE_CONFIG_HIGH))
        begin
            next_rdata = {8'h00, drive_config_high};
        end
        else if (hit(reg_addr_i, `ADDR_FUNCTION_SELECT_LOW))
        begin
            if (reg_word_i)
            begin
                next_rdata = {function_select_high,
                    function_select_low};
            end
            else
            begin
                next_rdata = {8'h00, function_select_low};
            end
        end
        else if (hit(reg_addr_i, `ADDR_FUNCTION_SELECT_HIGH))
        begin
            next_rdata = {8'h00, function_select_high};
        end
    end

    // Read data stands for exactly one cycle after the strobe.
    always @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            reg_rdata_o <= 16'h0000;
        end
        else if (reg_rd_i)
        begin
            reg_rdata_o <= next_rdata;
        end
        else
        begin
            reg_rdata_o <= 16'h0000;
        end
    end

    // Pin controls are registered so the pads see glitch-free levels.
    always @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            port_pin_out_o <= {PIN_COUNT{1'b0}};
            port_pin_oe_o <= {PIN_COUNT{1'b0}};
            pull_up_en_o <= {PIN_COUNT{1'b0}};
            pull_down_en_o <= {PIN_COUNT{1'b0}};
        end
        else
        begin
            port_pin_out_o <= next_pin_out;
            port_pin_oe_o <= next_pin_oe;
            pull_up_en_o <= next_pull_up;
            pull_down_en_o <= next_pull_down;
        end
    end

    // Peripheral inputs. The serial port input may come from either of
    // two pins; the lower pin wins if both select it, and the line idles
    // low when neither does.
    always @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            i2c_data_in_o <= 1'b0;
            i2c_clock_in_o <= 1'b0;
            uart_receive_o <= 1'b0;
            serial_port_data_in_o <= 1'b0;
            serial_port_clock_in_o <= 1'b0;
            adc_osc_waveform_in_o <= 1'b0;
            timer_even_ext_clock_o <= 1'b0;
            timer_odd_ext_clock_o <= 1'b0;
        end
        else
        begin
            i2c_data_in_o <= pin_level[0];
            i2c_clock_in_o <= pin_level[1];
            uart_receive_o <= pin_level[2];
            if (func_is(function_select_low, function_select_high, 0,
                `FUNC_TERTIARY))
            begin
                serial_port_data_in_o <= pin_level[0];
            end
            else if (func_is(function_select_low, function_select_high, 4,
                `FUNC_TERTIARY))
            begin
                serial_port_data_in_o <= pin_level[4];
            end
            else
            begin
                serial_port_data_in_o <= 1'b0;
            end
            if (func_is(function_select_low, function_select_high, 1,
                `FUNC_TERTIARY))
            begin
                serial_port_clock_in_o <= pin_level[1];
            end
            else if (func_is(function_select_low, function_select_high, 5,
                `FUNC_TERTIARY))
            begin
                serial_port_clock_in_o <= pin_level[5];
            end
            else
            begin
                serial_port_clock_in_o <= 1'b0;
            end
            adc_osc_waveform_in_o <= pin_level[4];
            timer_even_ext_clock_o <= pin_level[4];
            timer_odd_ext_clock_o <= pin_level[5];
        end
    end

endmodule

// *** verilog/gpio_port_regs.vh ***
/*
 * Register addresses, field layouts, reset values and function codes of
 * the eight-pin general-purpose port.
 * Assumes a 16-bit byte address from the processor's register port.
 */
`ifndef GPIO_PORT_REGS_VH
`define GPIO_PORT_REGS_VH

// Byte addresses of the port registers.
`define ADDR_PORT_DATA            16'hf220
`define ADDR_PORT_DIRECTION       16'hf221
`define ADDR_DRIVE_CONFIG_LOW     16'hf222
`define ADDR_DRIVE_CONFIG_HIGH    16'hf223
`define ADDR_FUNCTION_SELECT_LOW  16'hf224
`define ADDR_FUNCTION_SELECT_HIGH 16'hf225

// Reset values of all registers.
`define RST_PORT_DATA            8'h00
`define RST_PORT_DIRECTION       8'h00
`define RST_DRIVE_CONFIG_LOW     8'h00
`define RST_DRIVE_CONFIG_HIGH    8'h00
`define RST_FUNCTION_SELECT_LOW  8'h00
`define RST_FUNCTION_SELECT_HIGH 8'h00

// Direction bit values.
`define DIR_OUTPUT 1'h0
`define DIR_INPUT  1'h1

// Drive field codes, output mode.
`define DRIVE_HIGH_Z      2'h0
`define DRIVE_P_OPEN      2'h1
`define DRIVE_N_OPEN      2'h2
`define DRIVE_CMOS        2'h3
// Drive field codes, input mode.
`define PULL_NONE         2'h0
`define PULL_DOWN         2'h1
`define PULL_UP           2'h2

// Function field codes.
`define FUNC_GPIO      2'h0
`define FUNC_SECONDARY 2'h1
`define FUNC_TERTIARY  2'h2
`define FUNC_RESERVED  2'h3

// Pins that offer a tertiary function, one bit per pin.
`define TERTIARY_PINS 8'h7f

// Synchroniser depth for pin levels.
`define SYNC_STAGES 2

`endif
